// file: logic/pswc_power_switch_wake_control.v
`timescale 1ns/1ps
`include "pswc_defs.vh"

// =====================================================
// Power-state controller
module pswc_power_switch_wake_control
#(
    parameter SHORT_CYC = `PSWC_SHORT_S * `PSWC_CLK_HZ,
    parameter LONG_CYC  = `PSWC_LONG_S * `PSWC_CLK_HZ,
    parameter DEB_CYC   = (`PSWC_DEB_US * (`PSWC_CLK_HZ / 1000000))
)
(
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst,
    // Front-panel switch, high while pressed
    input  wire       pwr_sw,
    // Host software requests, one-cycle pulses
    input  wire       sw_off_req,
    input  wire       sw_s3_req,
    input  wire       sw_s4_req,
    input  wire       sw_on_req,
    // Firmware options
    input  wire       pme_wake_en,
    input  wire       s4_wake_os_ok,
    input  wire       rtc_alarm_set,
    // Wake sources, high when active
    input  wire       rtc_alarm,
    input  wire       lan_wake,
    input  wire       usb_wake,
    input  wire       pci_pme,
    input  wire       pcie_wake,
    input  wire       cir_wake,
    // State outputs
    output reg  [1:0] pwr_state_ff,
    output reg        sys_pwr_on_ff,
    output reg        wake_evt_ff
);

    // =====================================================
    // State codes
    localparam [1:0] ST_ON   = `PSWC_ST_S0;   // Working
    localparam [1:0] ST_STBY = `PSWC_ST_S3;   // Suspend to memory
    localparam [1:0] ST_HIBR = `PSWC_ST_S4;   // Suspend to disk
    localparam [1:0] ST_OFF  = `PSWC_ST_S5;   // Soft-off

    // =====================================================
    // Debounced switch
    wire sw_clean;   // Filtered switch level

    pswc_debounce #(.DEB_CYC(DEB_CYC)) u_deb
    (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .raw_in   (pwr_sw),
        .clean_ff (sw_clean)
    );

    // =====================================================
    // Press timer
    reg [`PSWC_CNT_W-1:0] press_cnt_ff;   // Press length in cycles
    reg                   sw_prev_ff;     // Last switch level
    reg                   long_done_ff;   // Long press already acted on

    wire release_evt = sw_prev_ff & ~sw_clean;
    wire short_press = release_evt & ~long_done_ff &
                       (press_cnt_ff < SHORT_CYC[`PSWC_CNT_W-1:0]);
    wire long_press  = sw_clean & ~long_done_ff &
                       (press_cnt_ff >= LONG_CYC[`PSWC_CNT_W-1:0]);

    // Release is seen in the same cycle the filtered level drops.
    // Short decision waits for release; long fires while held.
    // Presses between the two thresholds fall through silently.
    // Counter saturates so a stuck switch cannot wrap it.
    // Count while pressed, restart on release
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            press_cnt_ff <= {`PSWC_CNT_W{1'b0}};
            sw_prev_ff   <= 1'b0;
            long_done_ff <= 1'b0;
        end
        else
        begin
            sw_prev_ff <= sw_clean;
            if (!sw_clean)
            begin
                press_cnt_ff <= {`PSWC_CNT_W{1'b0}};
                long_done_ff <= 1'b0;
            end
            else
            begin
                // Saturate once long threshold reached
                if (press_cnt_ff < LONG_CYC[`PSWC_CNT_W-1:0])
                    press_cnt_ff <= press_cnt_ff + 28'h1;
                if (long_press)
                    long_done_ff <= 1'b1;
            end
        end
    end

    // =====================================================
    // Wake qualification
    wire wake_any = rtc_alarm | lan_wake | pcie_wake | cir_wake |
                    (pci_pme & pme_wake_en);
    wire wake_s3  = wake_any | usb_wake;
    wire wake_s4  = wake_any & s4_wake_os_ok;
    wire wake_s5  = (rtc_alarm & rtc_alarm_set) | lan_wake | pcie_wake |
                    cir_wake | (pci_pme & pme_wake_en);

    // Source wake for whichever sleep state is current
    wire wake_sleep = (pwr_state_ff == ST_STBY) ? wake_s3 : wake_s4;

    // =====================================================
    // Next-state logic
    reg [1:0] nxt_pwr_state;   // Next power state
    reg       nxt_wake_evt;    // Wake took effect

    // Priority per state; requests not valid here are ignored
    always @*
    begin
        nxt_pwr_state = pwr_state_ff;
        nxt_wake_evt  = 1'b0;
        case (pwr_state_ff)
            ST_ON:
            begin
                // Fail-safe hold beats any software request
                if (long_press)
                begin
                    nxt_pwr_state = ST_OFF;
                end
                // Software soft-off
                else if (sw_off_req)
                begin
                    nxt_pwr_state = ST_OFF;
                end
                // Short press sends the system to sleep
                else if (short_press)
                begin
                    nxt_pwr_state = ST_STBY;
                end
                // Host suspend to disk
                else if (sw_s4_req)
                begin
                    nxt_pwr_state = ST_HIBR;
                end
                // Host suspend to memory
                else if (sw_s3_req)
                begin
                    nxt_pwr_state = ST_STBY;
                end
            end
            ST_STBY, ST_HIBR:
            begin
                // Long hold drops straight to soft-off
                if (long_press)
                begin
                    nxt_pwr_state = ST_OFF;
                end
                // Short press wakes from either sleep state
                else if (short_press)
                begin
                    nxt_pwr_state = ST_ON;
                    nxt_wake_evt  = 1'b1;
                end
                // Enabled wake source for this sleep state
                else if (wake_sleep)
                begin
                    nxt_pwr_state = ST_ON;
                    nxt_wake_evt  = 1'b1;
                end
                // Software soft-off from sleep
                else if (sw_off_req)
                begin
                    nxt_pwr_state = ST_OFF;
                end
            end
            ST_OFF:
            begin
                // Switch or enabled source powers on
                if (short_press | wake_s5)
                begin
                    nxt_pwr_state = ST_ON;
                    nxt_wake_evt  = 1'b1;
                end
                // Host power-on request, no wake pulse
                else if (sw_on_req)
                begin
                    nxt_pwr_state = ST_ON;
                end
            end
            // Unused code falls back to soft-off
            default:
            begin
                nxt_pwr_state = ST_OFF;
            end
        endcase
    end

    // =====================================================
    // State registers
    // Power flag follows the next state so both change together
    always @(posedge sys_clk)
    begin
        // Reset lands in soft-off with power removed
        if (rst)
        begin
            pwr_state_ff  <= ST_OFF;
            sys_pwr_on_ff <= 1'b0;
            wake_evt_ff   <= 1'b0;
        end
        else
        begin
            pwr_state_ff  <= nxt_pwr_state;
            sys_pwr_on_ff <= (nxt_pwr_state == ST_ON);
            wake_evt_ff   <= nxt_wake_evt;
        end
    end

endmodule

// file: logic/pswc_defs.vh
// How it works
// - Short press in soft-off powers on
// - Short press while working enters sleep
// - Over six seconds working forces soft-off
// - Short press while sleeping wakes system
// - Over six seconds sleeping goes soft-off
// - Listed sources wake S3/S4/S5, USB S3 only
// - S4 wake only with OS support enabled
// - Software soft-off request removes system power
// - PME wakes only when firmware enables it
// - Programmed RTC alarm wakes from S5
`ifndef PSWC_DEFS_VH
`define PSWC_DEFS_VH

// =====================================================
// Power states
`define PSWC_ST_W        2
`define PSWC_ST_S0       2'h0
`define PSWC_ST_S3       2'h1
`define PSWC_ST_S4       2'h2
`define PSWC_ST_S5       2'h3

// =====================================================
// Timing
`define PSWC_CLK_HZ      20000000
`define PSWC_SHORT_S     4
`define PSWC_LONG_S      6
`define PSWC_DEB_US      10
`define PSWC_CNT_W       28
`define PSWC_DEB_W       8

`endif

// file: logic/pswc_debounce.v
`timescale 1ns/1ps
`include "pswc_defs.vh"

// =====================================================
// Switch debouncer
module pswc_debounce
#(
    parameter DEB_CYC = (`PSWC_DEB_US * (`PSWC_CLK_HZ / 1000000))
)
(
    // Clock and reset
    input  wire sys_clk,
    input  wire rst,
    // Raw and filtered level
    input  wire raw_in,
    output reg  clean_ff
);

    reg [`PSWC_DEB_W-1:0] cnt_ff;   // Stability counter

    // Follow input once stable for DEB_CYC cycles
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            cnt_ff   <= {`PSWC_DEB_W{1'b0}};
            clean_ff <= 1'b0;
        end
        else if (raw_in == clean_ff)
        begin
            cnt_ff <= {`PSWC_DEB_W{1'b0}};
        end
        else if (cnt_ff == DEB_CYC[`PSWC_DEB_W-1:0] - 8'h01)
        begin
            cnt_ff   <= {`PSWC_DEB_W{1'b0}};
            clean_ff <= raw_in;
        end
        else
        begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

endmodule

// file: tb/pswc_switch_model.sv
`timescale 1ns/1ps
// ======================================
// Front-panel switch, held for plen cycles
module pswc_switch_model
(
    input  wire        sys_clk,
    input  wire        go,
    input  wire  [7:0] plen,
    output logic       pwr_sw
);
    logic [7:0] cnt_ff = 8'h00;   // Cycles left pressed
    // Load on go, count down while pressed
    always @(posedge sys_clk)
    begin
        if (go)
            cnt_ff <= plen;
        else if (cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
    end
    assign pwr_sw = cnt_ff != 8'h00;  // Released line reads low
endmodule

// file: tb/pswc_chk.sv
`timescale 1ns/1ps
// ======================================
// Power-state checker
module pswc_chk
(
    input wire       sys_clk, rst, pwr_sw,
    input wire       sw_off_req, sw_s3_req, sw_s4_req, sw_on_req,
    input wire       pme_wake_en, s4_wake_os_ok, rtc_alarm_set,
    input wire       rtc_alarm, lan_wake, usb_wake, pci_pme, pcie_wake,
    input wire       cir_wake,
    input wire [1:0] pwr_state_ff,
    input wire       sys_pwr_on_ff, wake_evt_ff
);
    logic [3:0] low_ff;           // Released cycles, saturating
    wire  [1:0] st = pwr_state_ff;
    wire  [5:0] src = {rtc_alarm, lan_wake, usb_wake, pci_pme, pcie_wake,
                       cir_wake};
    wire        q = low_ff == 4'hf && !sw_on_req && !sw_off_req;
    // Debounce and press decision long settled once this saturates
    always @(posedge sys_clk)
    begin
        if (rst || pwr_sw)
            low_ff <= 4'h0;
        else if (low_ff != 4'hf)
            low_ff <= low_ff + 4'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_pwr; sys_pwr_on_ff == (st == 2'h0); endproperty
    a_pwr: assert property (p_pwr) else $error("power flag");
    property p_off; low_ff == 4'hf && sw_off_req && src == 6'h00
        && st != 2'h3 |=> st == 2'h3; endproperty
    a_off: assert property (p_off) else $error("soft off");
    property p_usb; q && src == 6'h08 && st[1] |=> $stable(st); endproperty
    a_usb: assert property (p_usb) else $error("usb wake");
    property p_pme; q && src == 6'h04 && !pme_wake_en && st != 2'h0
        |=> $stable(st); endproperty
    a_pme: assert property (p_pme) else $error("pme wake");
    property p_rtc; q && src == 6'h20 && !rtc_alarm_set && st == 2'h3
        |=> st == 2'h3; endproperty
    a_rtc: assert property (p_rtc) else $error("rtc wake");
    property p_s4; q && st == 2'h2 && !s4_wake_os_ok |=> st == 2'h2;
    endproperty
    a_s4: assert property (p_s4) else $error("s4 wake");
    property p_wake; q && st == 2'h1 && (src & 6'h3b) != 6'h00
        |=> st == 2'h0; endproperty
    a_wake: assert property (p_wake) else $error("s3 wake");
    property p_hold; q && !sw_s3_req && !sw_s4_req && st == 2'h0
        |=> st == 2'h0; endproperty
    a_hold: assert property (p_hold) else $error("own move");
    property p_evt; wake_evt_ff |-> st == 2'h0 ##1 !wake_evt_ff;
    endproperty
    a_evt: assert property (p_evt) else $error("wake pulse");
endmodule
bind pswc_power_switch_wake_control pswc_chk u_chk (.*);

// file: tb/pswc_power_switch_wake_control_tb.sv
`timescale 1ns/1ps
// ======================================
// Bench
module pswc_power_switch_wake_control_tb;
    logic       sys_clk = 0, rst = 1, go = 0, pme_en = 0, os_ok = 0;
    logic       rtc_set = 0, pwr_sw, pwr_on, evt;
    logic [3:0] req = 0;          // On, s4, s3, off
    logic [5:0] src = 0;          // Rtc lan usb pme pcie cir
    logic [7:0] plen = 0;
    logic [1:0] st;
    int         bad_count = 0, n_tests = 0, evt_cnt = 0;
    // Source, pme enable, rtc set, state after wake from soft-off
    logic [9:0] rows [8] = '{10'h204, 10'h203, 10'h100, 10'h083,
                             10'h048, 10'h043, 10'h020, 10'h010};
    always #25 sys_clk = ~sys_clk;
    pswc_switch_model sw (.sys_clk(sys_clk), .go(go), .plen(plen),
        .pwr_sw(pwr_sw));
    pswc_power_switch_wake_control #(.SHORT_CYC(20), .LONG_CYC(40),
        .DEB_CYC(4)) dut (.sys_clk(sys_clk), .rst(rst), .pwr_sw(pwr_sw),
        .sw_off_req(req[0]), .sw_s3_req(req[1]), .sw_s4_req(req[2]),
        .sw_on_req(req[3]), .pme_wake_en(pme_en), .s4_wake_os_ok(os_ok),
        .rtc_alarm_set(rtc_set), .rtc_alarm(src[5]), .lan_wake(src[4]),
        .usb_wake(src[3]), .pci_pme(src[2]), .pcie_wake(src[1]),
        .cir_wake(src[0]), .pwr_state_ff(st), .sys_pwr_on_ff(pwr_on),
        .wake_evt_ff(evt));
    task chk(input [2:0] got, input [1:0] e, input string nm);
    begin
        @(negedge sys_clk);
        n_tests++;
        if (got !== {e == 2'h0, e})
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, {e == 2'h0, e},
                     got);
        end
        $display("test %s done", nm);
    end
    endtask
    // Count wake pulses seen on the design output
    always @(negedge sys_clk)
    begin
        if (evt === 1'b1)
            evt_cnt <= evt_cnt + 1;
    end
    task drv(input [3:0] r, input [5:0] s);
    begin
        @(posedge sys_clk);
        req <= r;
        src <= s;
        @(posedge sys_clk);
        req <= 4'h0;
        src <= 6'h00;
        repeat (3) @(posedge sys_clk);
    end
    endtask
    task press(input [7:0] n);
    begin
        @(posedge sys_clk);
        plen <= n;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (n + 20) @(posedge sys_clk);
    end
    endtask
    task results;
    begin
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        chk({pwr_on, st}, 2'h3, "reset");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            pme_en <= rows[i][3];
            rtc_set <= rows[i][2];
            drv(4'h0, rows[i][9:4]);
            chk({pwr_on, st}, rows[i][1:0], "source");
            drv(4'h1, 6'h00);
            chk({pwr_on, st}, 2'h3, "off");
        end
        drv(4'h8, 6'h00);
        chk({pwr_on, st}, 2'h0, "on req");
        drv(4'h1, 6'h00);
        press(8'd8);
        chk({pwr_on, st}, 2'h0, "press off");
        press(8'd30);
        chk({pwr_on, st}, 2'h0, "mid press");
        press(8'd8);
        chk({pwr_on, st}, 2'h1, "press on");
        press(8'd8);
        chk({pwr_on, st}, 2'h0, "press s3");
        press(8'd60);
        chk({pwr_on, st}, 2'h3, "long on");
        drv(4'h8, 6'h00);
        drv(4'h2, 6'h00);
        press(8'd60);
        chk({pwr_on, st}, 2'h3, "long s3");
        drv(4'h8, 6'h00);
        drv(4'h4, 6'h00);
        drv(4'h0, 6'h10);
        chk({pwr_on, st}, 2'h2, "s4 no os");
        @(posedge sys_clk);
        os_ok <= 1'b1;
        drv(4'h0, 6'h10);
        chk({pwr_on, st}, 2'h0, "s4 os");
        drv(4'h2, 6'h00);
        drv(4'h0, 6'h08);
        chk({pwr_on, st}, 2'h0, "usb s3");
        chk({evt_cnt == 9, 2'h0}, 2'h0, "wake pulses");
        results;
    end
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        results;
    end
endmodule
